// [verilog/dcw_pkg.sv]
// Purpose: Shared constants and types of the dual watchdog block
// Assumes: 100 MHz ref_clk, 4 MHz oscillator rate for the timeout base
// Notes: Register byte address is four times the register index
package dcw_pkg;
  localparam int DCW_CLK_HZ = 100_000_000;
  localparam int DCW_OSC_HZ = 4_000_000;
  localparam int DCW_BUS_HZ = 2_000_000;
  localparam int DCW_OSC_DIV = DCW_CLK_HZ / DCW_OSC_HZ;
  // Nominal fixed timeout at the oscillator rate above; the counter width sets it exactly
  localparam int DCW_FIXED_NOMINAL_MS = 64;
  localparam int DCW_FIXED_BITS = 18;
  localparam int DCW_TIMER_BASE_BITS = 15;
  localparam int DCW_RATE_STEP = 2;
  localparam int DCW_RATE_MAX_BITS = 6;
  localparam int DCW_SPAN_W = 5;
  localparam int DCW_PREDIV_W = 16;

  localparam logic [15:0] DCW_IDX_SERVICE = 16'h001d;
  localparam logic [15:0] DCW_IDX_CONTROL = 16'h001e;
  localparam logic [15:0] DCW_IDX_OPT1 = 16'h1ff0;
  localparam logic [15:0] DCW_IDX_OPT2 = 16'h1ff1;
  localparam logic [15:0] DCW_IDX_STATUS = 16'h0020;
  localparam logic [15:0] DCW_IDX_ENABLE = 16'h0021;
  localparam logic [15:0] DCW_IDX_CLEAR = 16'h0022;

  localparam logic [7:0] DCW_SVC_ARM = 8'h55;
  localparam logic [7:0] DCW_SVC_FIRE = 8'haa;

  localparam int DCW_CTRL_EN_BIT = 2;
  localparam int DCW_CTRL_RATE_LSB = 0;
  localparam int DCW_OPT2_FIXED_EN_BIT = 0;
  localparam int DCW_OPT1_CLEAR_BIT = 0;
  localparam logic [2:0] DCW_CTRL_RESET = 3'h0;

  localparam int DCW_NUM_EVENTS = 3;
  localparam int DCW_ST_FIXED = 0;
  localparam int DCW_ST_TIMER = 1;
  localparam int DCW_ST_BADSEQ = 2;

  localparam logic [1:0] DCW_STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    DCW_REG_NONE, DCW_REG_SERVICE, DCW_REG_CONTROL, DCW_REG_OPT1,
    DCW_REG_OPT2, DCW_REG_STATUS, DCW_REG_ENABLE, DCW_REG_CLEAR
  } dcw_reg_t;
endpackage

// [verilog/dcw_wdog_counter.sv]
// Purpose: Watchdog count chain with selectable span and expiry pulse
// Assumes: tick is a one-cycle enable from the same clock
// Notes: restart and a stopped run both hold the count at zero
`timescale 1ns/100ps
module dcw_wdog_counter import dcw_pkg::*; #(
  parameter int WIDTH = DCW_FIXED_BITS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [DCW_SPAN_W-1:0] span,
  output logic [WIDTH-1:0] count,
  output logic expire
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic expire;
  } dcw_cnt_state_t;

  dcw_cnt_state_t state;
  dcw_cnt_state_t next_state;

  function automatic logic [WIDTH-1:0] span_mask(input logic [DCW_SPAN_W-1:0] bits);
    logic [WIDTH-1:0] m;
    m = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (i < int'(bits)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  always_comb begin
    next_state = state;
    next_state.expire = 1'b0;
    if (!run || restart) begin
      next_state.count = '0;
    end else if (tick) begin
      if (state.count == span_mask(span)) begin
        next_state.count = '0;
        next_state.expire = 1'b1;
      end else begin
        next_state.count = state.count + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;
  assign expire = state.expire;
endmodule // dcw_wdog_counter

// [verilog/dcw_watchdog.sv]
// Purpose: Fixed-period and timer-derived watchdogs behind an APB slave
// Assumes: Option bytes arrive as static strap pins; wdog_reset feeds system reset
// Notes: APB answers in one access cycle; unmapped or unaligned gives pslverr
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module dcw_watchdog import dcw_pkg::*; #(
  parameter int OSC_DIV = DCW_OSC_DIV,
  parameter int FIXED_BITS = DCW_FIXED_BITS,
  parameter int TIMER_BASE_BITS = DCW_TIMER_BASE_BITS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] option1_pins,
  input wire logic [7:0] option2_pins,
  output logic wdog_reset,
  output logic irq,
  output logic [7:0] pullup_enable
);
  localparam int TIMER_BITS = TIMER_BASE_BITS + DCW_RATE_MAX_BITS;

  typedef struct packed {
    logic [7:0] o1_s1;
    logic [7:0] o1_s2;
    logic [7:0] o1_s3;
    logic [7:0] o2_s1;
    logic [7:0] o2_s2;
    logic [7:0] o2_s3;
    logic [1:0] settle;
    logic loaded;
    logic [7:0] first_option_byte;
    logic [7:0] second_option_byte;
    logic [DCW_PREDIV_W-1:0] prediv;
    logic osc_tick;
    logic timer_wdog_enable;
    logic rate_select_high;
    logic rate_select_low;
    logic armed;
    logic [DCW_NUM_EVENTS-1:0] status;
    logic [DCW_NUM_EVENTS-1:0] enable;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wdog_reset;
    logic irq;
  } dcw_state_t;

  dcw_state_t state;
  dcw_state_t next_state;

  logic fixed_wdog_enable;
  logic timer_run;
  logic fixed_clear;
  logic timer_restart;
  logic bad_fire;
  logic [DCW_SPAN_W-1:0] timer_span;
  logic [FIXED_BITS-1:0] fixed_count;
  logic [TIMER_BITS-1:0] timer_count;
  logic fixed_expire;
  logic timer_expire;
  logic wr_access;
  dcw_reg_t acc_reg;

  function automatic dcw_reg_t decode_reg(input logic [15:0] addr);
    dcw_reg_t r;
    r = DCW_REG_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[15:2])
        DCW_IDX_SERVICE[13:0]: r = DCW_REG_SERVICE;
        DCW_IDX_CONTROL[13:0]: r = DCW_REG_CONTROL;
        DCW_IDX_OPT1[13:0]: r = DCW_REG_OPT1;
        DCW_IDX_OPT2[13:0]: r = DCW_REG_OPT2;
        DCW_IDX_STATUS[13:0]: r = DCW_REG_STATUS;
        DCW_IDX_ENABLE[13:0]: r = DCW_REG_ENABLE;
        DCW_IDX_CLEAR[13:0]: r = DCW_REG_CLEAR;
        default: r = DCW_REG_NONE;
      endcase
    end
    return r;
  endfunction

  // Fixed watchdog stays off until the option bytes are captured
  assign fixed_wdog_enable = state.loaded
    && state.second_option_byte[DCW_OPT2_FIXED_EN_BIT];
  // The fixed watchdog wins if both are configured
  assign timer_run = state.timer_wdog_enable && !fixed_wdog_enable;
  assign acc_reg = decode_reg(paddr);
  assign wr_access = psel && penable && state.pready && pwrite;
  assign fixed_clear = wr_access && acc_reg == DCW_REG_OPT1
    && !pwdata[DCW_OPT1_CLEAR_BIT];
  assign timer_restart = wr_access && acc_reg == DCW_REG_SERVICE
    && pwdata[7:0] == DCW_SVC_FIRE && state.armed;
  assign bad_fire = wr_access && acc_reg == DCW_REG_SERVICE
    && pwdata[7:0] == DCW_SVC_FIRE && !state.armed;
  // Each rate step adds two bits: x1, x4, x16, x64
  assign timer_span = DCW_SPAN_W'(TIMER_BASE_BITS
    + DCW_RATE_STEP * int'({state.rate_select_high, state.rate_select_low}));

  dcw_wdog_counter #(
    .WIDTH(FIXED_BITS)
  ) u_fixed (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick(state.osc_tick),
    .run(fixed_wdog_enable),
    .restart(fixed_clear),
    .span(DCW_SPAN_W'(FIXED_BITS)),
    .count(fixed_count),
    .expire(fixed_expire)
  );

  dcw_wdog_counter #(
    .WIDTH(TIMER_BITS)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick(state.osc_tick),
    .run(timer_run),
    .restart(timer_restart),
    .span(timer_span),
    .count(timer_count),
    .expire(timer_expire)
  );

  always_comb begin
    logic [DCW_NUM_EVENTS-1:0] events;
    logic [DCW_NUM_EVENTS-1:0] clr;
    events = '0;
    clr = '0;
    next_state = state;

    // Straps pass three flops; capture once the late stages agree
    next_state.o1_s1 = option1_pins;
    next_state.o1_s2 = state.o1_s1;
    next_state.o1_s3 = state.o1_s2;
    next_state.o2_s1 = option2_pins;
    next_state.o2_s2 = state.o2_s1;
    next_state.o2_s3 = state.o2_s2;
    if (!state.loaded) begin
      if (state.settle == DCW_STRAP_SETTLE) begin
        if (state.o1_s2 == state.o1_s3 && state.o2_s2 == state.o2_s3) begin
          next_state.loaded = 1'b1;
          next_state.first_option_byte = state.o1_s3;
          next_state.second_option_byte = state.o2_s3;
        end
      end else begin
        next_state.settle = state.settle + 2'h1;
      end
    end

    // Oscillator-rate tick: the 2 MHz bus runs at half this rate
    if (state.prediv == DCW_PREDIV_W'(OSC_DIV - 1)) begin
      next_state.prediv = '0;
      next_state.osc_tick = 1'b1;
    end else begin
      next_state.prediv = state.prediv + 1'b1;
      next_state.osc_tick = 1'b0;
    end

    // APB: setup cycle prepares the answer, access cycle completes it
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    if (psel && !penable) begin
      next_state.pready = 1'b1;
      next_state.pslverr = (acc_reg == DCW_REG_NONE);
      next_state.prdata = '0;
      if (!pwrite) begin
        unique case (acc_reg)
          DCW_REG_CONTROL: next_state.prdata = {29'h0, state.timer_wdog_enable,
            state.rate_select_high, state.rate_select_low};
          // Option byte contents only, never watchdog state
          DCW_REG_OPT1: next_state.prdata = {24'h0, state.first_option_byte};
          DCW_REG_OPT2: next_state.prdata = {24'h0, state.second_option_byte};
          DCW_REG_STATUS: next_state.prdata = {29'h0, state.status};
          DCW_REG_ENABLE: next_state.prdata = {29'h0, state.enable};
          DCW_REG_NONE, DCW_REG_SERVICE, DCW_REG_CLEAR: next_state.prdata = '0;
        endcase
      end
    end

    if (wr_access) begin
      unique case (acc_reg)
        DCW_REG_SERVICE: begin
          // Any service write other than 0x55 drops the armed state
          next_state.armed = (pwdata[7:0] == DCW_SVC_ARM);
        end
        DCW_REG_CONTROL: begin
          next_state.timer_wdog_enable = pwdata[DCW_CTRL_EN_BIT];
          next_state.rate_select_high = pwdata[DCW_CTRL_RATE_LSB + 1];
          next_state.rate_select_low = pwdata[DCW_CTRL_RATE_LSB];
        end
        DCW_REG_ENABLE: next_state.enable = pwdata[DCW_NUM_EVENTS-1:0];
        DCW_REG_CLEAR: clr = pwdata[DCW_NUM_EVENTS-1:0];
        // Option1 writes only clear the fixed count; pull-ups stay latched
        DCW_REG_OPT1, DCW_REG_OPT2, DCW_REG_STATUS, DCW_REG_NONE: begin
        end
      endcase
    end

    events[DCW_ST_FIXED] = fixed_expire;
    events[DCW_ST_TIMER] = timer_expire;
    events[DCW_ST_BADSEQ] = bad_fire;
    // A new event beats a clear in the same cycle
    next_state.status = (state.status & ~clr) | events;
    next_state.irq = |(next_state.status & next_state.enable);
    next_state.wdog_reset = fixed_expire || timer_expire;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.timer_wdog_enable <= DCW_CTRL_RESET[DCW_CTRL_EN_BIT];
      state.rate_select_high <= DCW_CTRL_RESET[DCW_CTRL_RATE_LSB + 1];
      state.rate_select_low <= DCW_CTRL_RESET[DCW_CTRL_RATE_LSB];
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign wdog_reset = state.wdog_reset;
  assign irq = state.irq;
  assign pullup_enable = state.first_option_byte;

  // Helper: APB read setup of option1 seen one cycle earlier
  logic rd_opt1_setup;
  assign rd_opt1_setup = psel && !penable && !pwrite && acc_reg == DCW_REG_OPT1;

  property p_fixed_full_span;
    @(posedge ref_clk) disable iff (!reset_n)
      fixed_expire |-> $past(fixed_count) == {FIXED_BITS{1'b1}};
  endproperty

  AST_FIXED_SPAN: assert property (p_fixed_full_span)
    else $error("fixed watchdog expired before its full span");

  AST_FIXED_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !fixed_wdog_enable |-> fixed_count == '0 && !fixed_expire)
    else $error("fixed watchdog active while not enabled");

  AST_RESET_ON_EXPIRE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (fixed_expire || timer_expire) |=> wdog_reset ##1 !wdog_reset)
    else $error("expiry did not raise a one-cycle system reset");

  AST_FIXED_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fixed_clear |=> fixed_count == '0 && !fixed_expire)
    else $error("option1 clear write did not restart fixed count");

  AST_OPT1_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_opt1_setup |=> pready && prdata == {24'h0, state.first_option_byte})
    else $error("option1 read did not return the option byte");

  AST_PULLUP_STABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(state.loaded) |-> $stable(pullup_enable))
    else $error("pull-up enables changed after capture");

  AST_TIMER_GATED: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!state.timer_wdog_enable || fixed_wdog_enable) |=> timer_count == '0)
    else $error("timer watchdog counted while disabled");

  AST_TIMER_SPAN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    timer_expire |-> $past(timer_count) == TIMER_BITS'((1 << $past(timer_span)) - 1))
    else $error("timer watchdog expired off its selected span");

  AST_SERVICE_SEQ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    timer_restart |=> timer_count == '0 ##1 !state.armed || timer_count <= 1)
    else $error("armed 0xAA write did not restart timer count");

  // A tick at the top of the span wraps to zero legally, so it is excluded
  AST_BAD_FIRE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bad_fire && timer_run && state.osc_tick
      && timer_count != TIMER_BITS'((1 << timer_span) - 1)
      |=> timer_count != '0 && state.status[DCW_ST_BADSEQ])
    else $error("unarmed 0xAA write restarted timer or was not flagged");

  AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ((fixed_expire && state.enable[DCW_ST_FIXED])
      || (timer_expire && state.enable[DCW_ST_TIMER])
      || (bad_fire && state.enable[DCW_ST_BADSEQ]))
      && !(wr_access && acc_reg == DCW_REG_ENABLE) |=> irq)
    else $error("enabled event did not raise the interrupt");

  AST_PREADY_ONE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    psel && !penable |=> pready ##1 !pready)
    else $error("pready was not a one-cycle answer to setup");

  AST_SLVERR_BAD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    psel && !penable && acc_reg == DCW_REG_NONE |=> pslverr)
    else $error("unmapped access did not raise pslverr");

  AST_SLVERR_OK: assert property (@(posedge ref_clk) disable iff (!reset_n)
    psel && !penable && acc_reg != DCW_REG_NONE |=> !pslverr)
    else $error("mapped access raised pslverr");

  // Status bits only drop through the clear register
  AST_STATUS_STICKY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(wr_access && acc_reg == DCW_REG_CLEAR)
      |=> (state.status & $past(state.status)) == $past(state.status))
    else $error("status bit dropped without a clear write");

  AST_FIXED_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fixed_expire |=> state.status[DCW_ST_FIXED] && wdog_reset)
    else $error("fixed expiry was not flagged with a reset");

  AST_OPT1_WRITE_KEEP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state.loaded && wr_access && acc_reg == DCW_REG_OPT1 |=> $stable(pullup_enable))
    else $error("option1 write changed the pull-up enables");

  AST_STRAP_CAPTURE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(state.loaded) |-> state.second_option_byte == state.o2_s3
      && state.first_option_byte == state.o1_s3)
    else $error("option bytes captured from an unsettled strap");

  AST_ARM_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_access && acc_reg == DCW_REG_SERVICE && pwdata[7:0] == DCW_SVC_ARM |=> state.armed)
    else $error("0x55 service write did not arm the sequence");

  AST_ARM_DROP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_access && acc_reg == DCW_REG_SERVICE && pwdata[7:0] != DCW_SVC_ARM |=> !state.armed)
    else $error("non-arming service write left the sequence armed");

  AST_CTRL_ENABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_access && acc_reg == DCW_REG_CONTROL && pwdata[DCW_CTRL_EN_BIT]
      |=> state.timer_wdog_enable)
    else $error("control write did not enable the timer watchdog");

  COV_RATE_TOP: cover property (@(posedge ref_clk) disable iff (!reset_n)
    timer_expire && state.rate_select_high && state.rate_select_low);
  COV_FIXED_EXPIRE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    fixed_expire);
  COV_TIMER_EXPIRE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    timer_expire && state.rate_select_low);
  COV_SERVICE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    timer_restart);
  COV_BAD_FIRE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    bad_fire ##1 irq);
endmodule // dcw_watchdog

// [dv/dual_cop_watchdog_bench.sv]
// Purpose: Self-checking bench for the dual watchdog block over APB
// Assumes: Shortened counts (OSC_DIV 2, FIXED_BITS 4, TIMER_BASE_BITS 3)
// Notes: Expiry times are checked inside a small window to absorb tick phase
`timescale 1ns/100ps
module dual_cop_watchdog_bench import dcw_pkg::*; ;
  localparam int OD = 2;
  localparam int FB = 4;
  localparam int TB = 3;
  localparam int LIMIT = 20000;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] option1_pins = 8'h00;
  logic [7:0] option2_pins = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wdog_reset;
  logic irq;
  logic [7:0] pullup_enable;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int rst_seen = 0;
  int r0;
  logic [31:0] rd;
  logic er;

  dcw_watchdog #(.OSC_DIV(OD), .FIXED_BITS(FB), .TIMER_BASE_BITS(TB)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .option1_pins(option1_pins),
    .option2_pins(option2_pins), .wdog_reset(wdog_reset), .irq(irq),
    .pullup_enable(pullup_enable)
  );

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (wdog_reset === 1'b1) begin
      rst_seen <= rst_seen + 1;
    end
  end

  // A hang anywhere ends the run through the same verdict path
  always @(posedge ref_clk) begin
    if (cyc == LIMIT) begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready_timeout", 32'h1, 32'h0);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] ba(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, ba(idx), d);
  endtask

  task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, ba(idx), 32'h0000_0000);
    chk(nm, exp, rd);
    chk("rd_err", 32'h0, {31'h0, er});
  endtask

  task automatic do_reset(input logic [7:0] o1, input logic [7:0] o2);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    option1_pins <= o1;
    option2_pins <= o2;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic wait_rst(input string nm, input int exp);
    int n;
    n = 0;
    while (wdog_reset !== 1'b1 && n < exp + 40) begin
      @(posedge ref_clk);
      n++;
    end
    chk_rng(nm, exp - 3, exp + 4, n);
    @(posedge ref_clk);
  endtask

  task automatic t_regs();
    do_reset(8'h0f, 8'h00);
    rdc("opt1_read", DCW_IDX_OPT1, 32'h0000_000f);
    chk("pullups", 32'h0000_000f, {24'h0, pullup_enable});
    rdc("opt2_read", DCW_IDX_OPT2, 32'h0000_0000);
    rdc("ctrl_reset", DCW_IDX_CONTROL, 32'h0000_0000);
    wr(DCW_IDX_CONTROL, 32'h0000_0003);
    rdc("ctrl_rw", DCW_IDX_CONTROL, 32'h0000_0003);
    wr(DCW_IDX_CONTROL, 32'h0000_0000);
    rdc("svc_read", DCW_IDX_SERVICE, 32'h0000_0000);
    apb(1'b0, ba(16'h0030), 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b0, 16'h0079, 32'h0000_0000);
    chk("unaligned_err", 32'h1, {31'h0, er});
    r0 = rst_seen;
    repeat (100) @(posedge ref_clk);
    chk("no_fixed_when_off", r0, rst_seen);
  endtask

  task automatic t_fixed();
    do_reset(8'h0f, 8'h01);
    wr(DCW_IDX_OPT1, 32'h0000_0000);
    wr(DCW_IDX_ENABLE, 32'h0000_0007);
    wr(DCW_IDX_CONTROL, 32'h0000_0004);
    r0 = rst_seen;
    // Clearing writes carry other bits to show they never touch the pull-ups
    repeat (6) begin
      wr(DCW_IDX_OPT1, 32'h0000_00f0);
      repeat (10) @(posedge ref_clk);
    end
    chk("fixed_serviced", r0, rst_seen);
    chk("pullups_kept", 32'h0000_000f, {24'h0, pullup_enable});
    rdc("opt1_after_clear", DCW_IDX_OPT1, 32'h0000_000f);
    wr(DCW_IDX_CONTROL, 32'h0000_0000);
    wr(DCW_IDX_OPT1, 32'h0000_0000);
    wait_rst("fixed_period", (1 << FB) * OD + 2);
    chk("fixed_irq", 32'h1, {31'h0, irq});
    wr(DCW_IDX_OPT1, 32'h0000_0000);
    rdc("fixed_status", DCW_IDX_STATUS, 32'h0000_0001);
    wr(DCW_IDX_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk("fixed_irq_clr", 32'h0, {31'h0, irq});
  endtask

  task automatic t_timer();
    do_reset(8'h00, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr(DCW_IDX_CONTROL, 32'h0000_0004 | r);
      wr(DCW_IDX_SERVICE, {24'h0, DCW_SVC_ARM});
      wr(DCW_IDX_SERVICE, {24'h0, DCW_SVC_FIRE});
      wait_rst("timer_period", (1 << (TB + 2 * r)) * OD + 2);
      wr(DCW_IDX_CONTROL, 32'h0000_0000);
      wr(DCW_IDX_CLEAR, 32'h0000_0007);
    end
  endtask

  task automatic t_service();
    wr(DCW_IDX_ENABLE, 32'h0000_0000);
    wr(DCW_IDX_CONTROL, 32'h0000_0004);
    r0 = rst_seen;
    repeat (5) begin
      wr(DCW_IDX_SERVICE, {24'h0, DCW_SVC_ARM});
      wr(DCW_IDX_SERVICE, {24'h0, DCW_SVC_FIRE});
    end
    chk("timer_serviced", r0, rst_seen);
    // Lone fire writes must not restart, so exactly one expiry lands here
    repeat (8) wr(DCW_IDX_SERVICE, {24'h0, DCW_SVC_FIRE});
    chk("unarmed_expiry", r0 + 1, rst_seen);
    wr(DCW_IDX_CONTROL, 32'h0000_0000);
    rdc("timer_status", DCW_IDX_STATUS, 32'h0000_0006);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(DCW_IDX_ENABLE, 32'h0000_0004);
    repeat (2) @(posedge ref_clk);
    chk("irq_enabled", 32'h1, {31'h0, irq});
    wr(DCW_IDX_CLEAR, 32'h0000_0006);
    repeat (2) @(posedge ref_clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rdc("status_cleared", DCW_IDX_STATUS, 32'h0000_0000);
  endtask

  initial begin
    t_regs();
    t_fixed();
    t_timer();
    t_service();
    wrap_up();
  end
endmodule // dual_cop_watchdog_bench
